// File: logic/pscr_pkg.sv
// package: offsets, field positions, reset values, delay tables
package pscr_pkg;
	// =====================================================
	// register command codes
	localparam logic [7:0] ADDR_IOUT_STATUS = 8'h7b;
	localparam logic [7:0] ADDR_CML_STATUS  = 8'h7e;
	localparam logic [7:0] ADDR_SCRATCH     = 8'hd0;
	localparam logic [7:0] ADDR_DELAY_SEL   = 8'hd1;
	localparam logic [7:0] ADDR_STRAP_OVR   = 8'hd2;
	// =====================================================
	// output-current status fields
	localparam int BIT_POS_OC   = 7;
	localparam int BIT_OC_UV    = 6;
	localparam int BIT_NEG_OC   = 4;
	// communication status fields
	localparam int BIT_BAD_CMD  = 7;
	localparam int BIT_BAD_DATA = 6;
	localparam int BIT_PEC_FAIL = 5;
	localparam int BIT_OTHER    = 1;
	// delay select fields
	localparam int PGD_LSB      = 3;
	localparam int POD_LSB      = 0;
	// strap override fields
	localparam int BIT_TRACK    = 7;
	localparam int BIT_SEQ      = 6;
	localparam int BIT_FSKIP    = 4;
	localparam int SST_LSB      = 2;
	localparam int BIT_UVRESP   = 1;
	localparam int BIT_CMODE    = 0;
	// =====================================================
	// reset values
	localparam logic [7:0] SCRATCH_RST   = 8'h00;
	localparam logic [2:0] PGD_RST       = 3'h2;
	localparam logic [2:0] POD_RST       = 3'h2;
	localparam logic       FSKIP_RST     = 1'b1;
	// =====================================================
	// timing: 256 us base, doubling per code
	localparam int CLK_KHZ        = 40000;
	localparam int DLY_BASE_US    = 256;
	localparam int DLY_BASE_CYC   = DLY_BASE_US * CLK_KHZ / 1000;
	localparam int PGD_TOP_US     = 131072;
	localparam int PGD_TOP_CYC    = PGD_TOP_US * (CLK_KHZ / 1000);
	localparam int SST_BASE_MS    = 1;
	localparam int SST_BASE_CYC   = SST_BASE_MS * CLK_KHZ;
	localparam int DLY_W          = 23;
endpackage

// File: logic/pscr_delay_decode.sv
// decoder: delay and soft-start select codes to clock-cycle counts
`timescale 1ns/10ps
module pscr_delay_decode
	import pscr_pkg::*;
(
	input  wire logic [2:0]       i_pgd_sel,
	input  wire logic [2:0]       i_pod_sel,
	input  wire logic [1:0]       i_sst_sel,
	output logic      [DLY_W-1:0] o_pgd_cyc,
	output logic      [DLY_W-1:0] o_pod_cyc,
	output logic      [DLY_W-1:0] o_sst_cyc
);
	localparam logic [DLY_W-1:0] BASE = DLY_W'(DLY_BASE_CYC);
	localparam logic [DLY_W-1:0] PTOP = DLY_W'(PGD_TOP_CYC);
	localparam logic [DLY_W-1:0] SBAS = DLY_W'(SST_BASE_CYC);

	always_comb
	begin
		// top power-good code breaks the doubling pattern
		if (i_pgd_sel == 3'h7)
			o_pgd_cyc = PTOP;
		else
			o_pgd_cyc = BASE << i_pgd_sel;
		o_pod_cyc = BASE << i_pod_sel;
		o_sst_cyc = SBAS << i_sst_sel;
	end
endmodule

// File: logic/pscr_regs.sv
// register slice: current and bad_command_flag status, scratch, delays, strap override
`timescale 1ns/10ps
// Notes on behaviour
// - status bit 7 reports a positive output overcurrent fault.
// - status bit 6 reports overcurrent together with undervoltage.
// - status bit 4 reports a negative output overcurrent fault.
// - bad_command_flag bit 7 reports an invalid or unsupported command code.
// - bad_command_flag bit 6 reports invalid or unsupported data.
// - bad_command_flag bit 5 flags a failed packet error check.
// - bad_command_flag bit 1 reports other faults, currently too many data bytes.
// - scratch register holds the last written byte, no side effects.
// - power-good delay code at bits 5:3, reset 010b, top code 131.072 ms.
// - power-on delay code at bits 2:0, reset 010b, 256 us doubling.
// - override values last only until the next power-on reset.
// - strap fields load from straps at power-up, host may overwrite.
// - override bit 7 selects internal reference or external tracking.
// - override bit 6 selects internal soft-start or external sequencing.
// - override bit 4, reset 1, forces skip mode during soft start.
// - override bits 3:2 select soft start of 1, 2, 4 or 8 ms.
// - override bit 1 selects hiccup or latch-off on undervoltage.
// - override bit 0 selects skip or forced continuous conduction.
module pscr_regs
	import pscr_pkg::*;
(
	input  wire logic             i_sys_clk,
	input  wire logic             i_nrst,
	input  wire logic             i_ce,
	// register port from the transport
	input  wire logic [7:0]       i_cmd_code,
	input  wire logic             i_wr_en,
	input  wire logic             i_rd_en,
	input  wire logic [7:0]       i_wr_data,
	output logic      [7:0]       o_rd_data,
	output logic                  o_rd_valid,
	output logic                  o_cmd_unsupported,
	// fault levels from the analog detectors
	input  wire logic             i_pos_oc_fault,
	input  wire logic             i_uv_fault,
	input  wire logic             i_neg_oc_fault,
	// bad_command_flag fault levels from the transport
	input  wire logic             i_bad_cmd,
	input  wire logic             i_bad_data,
	input  wire logic             i_pec_fail,
	input  wire logic             i_too_many_bytes,
	// pin straps
	input  wire logic             i_strap_track,
	input  wire logic             i_strap_seq,
	input  wire logic [1:0]       i_strap_sst,
	input  wire logic             i_strap_uvresp,
	input  wire logic             i_strap_cmode,
	// configuration outputs and the soft-start activity input
	output logic                  o_tracking_select,
	output logic                  o_sequencing_select,
	output logic                  o_force_skip_during_softstart,
	output logic                  o_softstart_skip_now,
	output logic                  o_undervoltage_response_sel,
	output logic                  o_conduction_mode_sel,
	output logic      [DLY_W-1:0] o_power_good_delay_cyc,
	output logic      [DLY_W-1:0] o_power_on_delay_cyc,
	output logic      [DLY_W-1:0] o_softstart_cyc,
	input  wire logic             i_softstart_active
);
	import pscr_pkg::*;

	// =====================================================
	// state
	typedef struct packed {
		logic [3:0]       sync1;
		logic [3:0]       sync2;
		logic [6:0]       stsync1;
		logic [6:0]       stsync2;
		logic             strap_done;
		logic [7:0]       scratch;
		logic [2:0]       power_good_delay_sel;
		logic [2:0]       power_on_delay_sel;
		logic             tracking_select;
		logic             seq;
		logic             fskip;
		logic [1:0]       softstart_time_sel;
		logic             uvr;
		logic             cm;
		logic [7:0]       rd_data;
		logic             rd_valid;
		logic             unsup;
		logic             ss_skip;
		logic [DLY_W-1:0] pgd_cyc;
		logic [DLY_W-1:0] pod_cyc;
		logic [DLY_W-1:0] sst_cyc;
	} pscr_state_t;

	pscr_state_t      st_r;
	pscr_state_t      st_nxt;
	logic [DLY_W-1:0] pgd_cyc;
	logic [DLY_W-1:0] pod_cyc;
	logic [DLY_W-1:0] sst_cyc;
	logic [7:0]       iout_v;
	logic [7:0]       cml_v;
	logic [7:0]       dly_v;
	logic [7:0]       ovr_v;

	pscr_delay_decode u_dec (
		.i_pgd_sel (st_r.power_good_delay_sel),
		.i_pod_sel (st_r.power_on_delay_sel),
		.i_sst_sel (st_r.softstart_time_sel),
		.o_pgd_cyc (pgd_cyc),
		.o_pod_cyc (pod_cyc),
		.o_sst_cyc (sst_cyc)
	);

	// =====================================================
	// read views
	always_comb
	begin
		iout_v = 8'h00;
		iout_v[BIT_POS_OC] = st_r.sync2[0];
		iout_v[BIT_OC_UV]  = st_r.sync2[0] & st_r.sync2[1];
		iout_v[BIT_NEG_OC] = st_r.sync2[2];
		cml_v = 8'h00;
		cml_v[BIT_BAD_CMD]  = i_bad_cmd;
		cml_v[BIT_BAD_DATA] = i_bad_data;
		cml_v[BIT_PEC_FAIL] = i_pec_fail;
		cml_v[BIT_OTHER]    = i_too_many_bytes;
		dly_v = 8'h00;
		dly_v[PGD_LSB +: 3] = st_r.power_good_delay_sel;
		dly_v[POD_LSB +: 3] = st_r.power_on_delay_sel;
		ovr_v = 8'h00;
		ovr_v[BIT_TRACK]     = st_r.tracking_select;
		ovr_v[BIT_SEQ]       = st_r.seq;
		ovr_v[BIT_FSKIP]     = st_r.fskip;
		ovr_v[SST_LSB +: 2]  = st_r.softstart_time_sel;
		ovr_v[BIT_UVRESP]    = st_r.uvr;
		ovr_v[BIT_CMODE]     = st_r.cm;
	end

	// =====================================================
	// next state
	always_comb
	begin
		st_nxt = st_r;
		// analog faults cross in through two flops
		st_nxt.sync1 = {1'b0, i_neg_oc_fault, i_uv_fault, i_pos_oc_fault};
		st_nxt.sync2 = st_r.sync1;
		st_nxt.stsync1 = {i_strap_track, i_strap_seq, i_strap_sst,
			i_strap_uvresp, i_strap_cmode, i_softstart_active};
		st_nxt.stsync2 = st_r.stsync1;
		st_nxt.rd_valid = 1'b0;
		st_nxt.unsup = 1'b0;
		// straps are caught once the sync chain has filled after reset
		if (!st_r.strap_done)
		begin
			// marker must leave both flops so stsync2 holds real straps
			st_nxt.strap_done = ~(st_r.sync1[3] | st_r.sync2[3]);
			st_nxt.tracking_select = st_r.stsync2[6];
			st_nxt.seq = st_r.stsync2[5];
			st_nxt.softstart_time_sel = st_r.stsync2[4:3];
			st_nxt.uvr = st_r.stsync2[2];
			st_nxt.cm  = st_r.stsync2[1];
		end
		if (i_wr_en)
		begin
			unique case (i_cmd_code)
				ADDR_SCRATCH:
					st_nxt.scratch = i_wr_data;
				ADDR_DELAY_SEL:
				begin
					st_nxt.power_good_delay_sel = i_wr_data[PGD_LSB +: 3];
					st_nxt.power_on_delay_sel = i_wr_data[POD_LSB +: 3];
				end
				ADDR_STRAP_OVR:
				begin
					st_nxt.tracking_select   = i_wr_data[BIT_TRACK];
					st_nxt.seq   = i_wr_data[BIT_SEQ];
					st_nxt.fskip = i_wr_data[BIT_FSKIP];
					st_nxt.softstart_time_sel   = i_wr_data[SST_LSB +: 2];
					st_nxt.uvr   = i_wr_data[BIT_UVRESP];
					st_nxt.cm    = i_wr_data[BIT_CMODE];
				end
				// status registers take no writes
				ADDR_IOUT_STATUS, ADDR_CML_STATUS: ;
				default:
					st_nxt.unsup = 1'b1;
			endcase
		end
		if (i_rd_en)
		begin
			st_nxt.rd_valid = 1'b1;
			unique case (i_cmd_code)
				ADDR_IOUT_STATUS: st_nxt.rd_data = iout_v;
				ADDR_CML_STATUS:  st_nxt.rd_data = cml_v;
				ADDR_SCRATCH:     st_nxt.rd_data = st_r.scratch;
				ADDR_DELAY_SEL:   st_nxt.rd_data = dly_v;
				ADDR_STRAP_OVR:   st_nxt.rd_data = ovr_v;
				default:
				begin
					st_nxt.rd_data = 8'h00;
					st_nxt.unsup = 1'b1;
				end
			endcase
		end
		// skip forced while ramping only when the force bit is set
		st_nxt.ss_skip = st_r.fskip & st_r.stsync2[0];
		st_nxt.pgd_cyc = pgd_cyc;
		st_nxt.pod_cyc = pod_cyc;
		st_nxt.sst_cyc = sst_cyc;
	end

	// =====================================================
	// registers; power-on reset drops every override
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_nrst)
		begin
			st_r <= '0;
			st_r.scratch <= SCRATCH_RST;
			st_r.power_good_delay_sel <= PGD_RST;
			st_r.power_on_delay_sel <= POD_RST;
			st_r.fskip <= FSKIP_RST;
			st_r.sync1[3] <= 1'b1;
		end
		else if (i_ce)
			st_r <= st_nxt;
	end

	assign o_rd_data = st_r.rd_data;
	assign o_rd_valid = st_r.rd_valid;
	assign o_cmd_unsupported = st_r.unsup;
	assign o_tracking_select = st_r.tracking_select;
	assign o_sequencing_select = st_r.seq;
	assign o_force_skip_during_softstart = st_r.fskip;
	assign o_softstart_skip_now = st_r.ss_skip;
	assign o_undervoltage_response_sel = st_r.uvr;
	assign o_conduction_mode_sel = st_r.cm;
	assign o_power_good_delay_cyc = st_r.pgd_cyc;
	assign o_power_on_delay_cyc = st_r.pod_cyc;
	assign o_softstart_cyc = st_r.sst_cyc;
endmodule

// File: test/pscr_host.sv
// host model: single-byte reads and writes on the register port
`timescale 1ns/10ps
module pscr_host
(
	input  wire logic       i_sys_clk,
	input  wire logic [7:0] i_rd_data,
	input  wire logic       i_rd_valid,
	input  wire logic       i_unsup,
	output logic      [7:0] o_cmd_code,
	output logic            o_wr_en,
	output logic            o_rd_en,
	output logic      [7:0] o_wr_data
);
	initial
	begin
		{o_cmd_code, o_wr_en, o_rd_en, o_wr_data} = 18'h0;
	end
	// ======================================================
	// strobes rise and fall on falling edges
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_sys_clk);
		{o_cmd_code, o_wr_data, o_wr_en} = {a, d, 1'b1};
		@(negedge i_sys_clk);
		// released data is inverted so a stale byte never looks valid
		{o_wr_en, o_wr_data} = {1'b0, ~d};
	endtask
	task automatic rd(input logic [7:0] a, output logic [9:0] r);
		@(negedge i_sys_clk);
		{o_cmd_code, o_rd_en} = {a, 1'b1};
		@(negedge i_sys_clk);
		o_rd_en = 1'b0;
		r = {i_rd_valid, i_unsup, i_rd_data};
	endtask
endmodule

// File: test/pscr_regs_asserts.sv
// checker: register port answers and decoded outputs
`timescale 1ns/10ps
module pscr_regs_asserts
	import pscr_pkg::*;
(
	input wire logic             i_sys_clk,
	input wire logic             i_nrst,
	input wire logic             i_ce,
	input wire logic [7:0]       i_cmd_code,
	input wire logic             i_wr_en,
	input wire logic             i_rd_en,
	input wire logic [7:0]       i_wr_data,
	input wire logic [7:0]       o_rd_data,
	input wire logic             o_rd_valid,
	input wire logic             o_cmd_unsupported,
	input wire logic             o_tracking_select,
	input wire logic             o_conduction_mode_sel,
	input wire logic             o_force_skip_during_softstart,
	input wire logic [DLY_W-1:0] o_power_good_delay_cyc,
	input wire logic [DLY_W-1:0] o_power_on_delay_cyc,
	input wire logic [DLY_W-1:0] o_softstart_cyc
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);
	logic map;
	assign map = i_cmd_code inside {8'h7b, 8'h7e, 8'hd0, 8'hd1, 8'hd2};
	sequence s_rd; i_ce && i_rd_en; endsequence
	sequence s_wr(a); i_ce && i_wr_en && i_cmd_code == a; endsequence
	// ======================================================
	a_rd_answer: assert property (s_rd ##0 map |=> o_rd_valid)
		else $error("read without answer");
	a_no_strobe: assert property (i_ce && !i_rd_en |=> !o_rd_valid)
		else $error("answer without read");
	a_ce_hold: assert property (!i_ce |=> $stable(o_rd_valid) &&
		$stable(o_rd_data) && $stable(o_softstart_cyc))
		else $error("state moved while clock enable low");
	a_unmap_flag: assert property (s_rd ##0 !map |=> o_cmd_unsupported)
		else $error("unmapped read not flagged");
	a_unmap_zero: assert property (s_rd ##0 !map |=> o_rd_data == 8'h00)
		else $error("unmapped read not zero");
	a_ovr_bits: assert property (s_wr(8'hd2) |=>
		o_tracking_select == $past(i_wr_data[7]) &&
		o_force_skip_during_softstart == $past(i_wr_data[4]) &&
		o_conduction_mode_sel == $past(i_wr_data[0]))
		else $error("override fields not taken");
	a_sst_count: assert property (s_wr(8'hd2) |-> ##2
		o_softstart_cyc == 40000 << $past(i_wr_data[3:2], 2))
		else $error("soft-start count wrong");
	a_pgd_count: assert property (s_wr(8'hd1) |-> ##2
		o_power_good_delay_cyc == ($past(i_wr_data[5:3], 2) == 3'h7 ?
		5242880 : 10240 << $past(i_wr_data[5:3], 2)))
		else $error("power-good count wrong");
	a_pod_count: assert property (s_wr(8'hd1) |-> ##2
		o_power_on_delay_cyc == 10240 << $past(i_wr_data[2:0], 2))
		else $error("power-on count wrong");
	a_reset_vals: assert property (disable iff (1'b0) !i_nrst |=>
		o_rd_data == 8'h00 && !o_rd_valid && o_force_skip_during_softstart)
		else $error("reset values wrong");
endmodule
bind pscr_regs pscr_regs_asserts i_pscr_regs_asserts (.*);

// File: test/tb.sv
// testbench: reset, register traffic, fault status, strap reload
`timescale 1ns/10ps
module tb;
	import pscr_pkg::*;
	logic             clk, nrst, ce, wr, rd, rdv, uns, act;
	logic             tracking_select, sq, fs, uvr, cm, skp;
	logic [7:0]       cmd, wd, rdd;
	logic [6:0]       flt;
	logic [5:0]       strp;
	logic [DLY_W-1:0] pgc, poc, stc;
	logic [9:0]       r;
	int               n_fail, n_tests, cyc, v;
	pscr_regs i_pscr_regs (.i_sys_clk(clk), .i_nrst(nrst), .i_ce(ce),
		.i_cmd_code(cmd), .i_wr_en(wr), .i_rd_en(rd), .i_wr_data(wd),
		.o_rd_data(rdd), .o_rd_valid(rdv), .o_cmd_unsupported(uns),
		.i_pos_oc_fault(flt[6]), .i_uv_fault(flt[5]), .i_neg_oc_fault(flt[4]),
		.i_bad_cmd(flt[3]), .i_bad_data(flt[2]), .i_pec_fail(flt[1]),
		.i_too_many_bytes(flt[0]), .i_strap_track(strp[5]),
		.i_strap_seq(strp[4]), .i_strap_sst(strp[3:2]),
		.i_strap_uvresp(strp[1]), .i_strap_cmode(strp[0]),
		.o_tracking_select(tracking_select), .o_sequencing_select(sq),
		.o_force_skip_during_softstart(fs), .o_softstart_skip_now(skp),
		.o_undervoltage_response_sel(uvr), .o_conduction_mode_sel(cm),
		.o_power_good_delay_cyc(pgc), .o_power_on_delay_cyc(poc),
		.o_softstart_cyc(stc), .i_softstart_active(act));
	pscr_host i_pscr_host (.i_sys_clk(clk), .i_rd_data(rdd),
		.i_rd_valid(rdv), .i_unsup(uns), .o_cmd_code(cmd), .o_wr_en(wr),
		.o_rd_en(rd), .o_wr_data(wd));
	// ======================================================
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_fail++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic rchk(logic [7:0] a, logic [7:0] e);
		i_pscr_host.rd(a, r);
		chk("read", {2'b10, e}, r);
	endtask
	task automatic conclude;
		if (n_fail == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// strap writes must wait for the post-reset strap load
	task automatic reset_dut;
		strp = 6'($urandom);
		nrst = 1'b0;
		repeat (20) @(negedge clk);
		nrst = 1'b1;
		repeat (5) @(negedge clk);
		rchk(8'hd2, {strp[5:4], 2'b01, strp[3:0]});
		chk("cfg", {strp[5:4], 1'b1, strp[1:0]}, {tracking_select, sq, fs, uvr, cm});
		rchk(8'hd1, 8'h12);
		rchk(8'hd0, 8'h00);
	endtask
	// ======================================================
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 5000)
		begin
			n_fail++;
			conclude;
		end
	end
	initial
	begin
		{nrst, ce, flt, act, n_fail, n_tests, cyc} = 0;
		ce = 1'b1;
		v = $urandom(32'h1631);
		reset_dut;
		for (int i = 0; i < 8; i++)
		begin
			v = $urandom;
			i_pscr_host.wr(8'hd0, v[7:0]);
			i_pscr_host.wr(8'h7b, ~v[7:0]);
			rchk(8'hd0, v[7:0]);
			i_pscr_host.wr(8'hd2, v[15:8]);
			rchk(8'hd2, v[15:8] & 8'hdf);
			chk("cfg", {v[15:14], v[12], v[9:8]}, {tracking_select, sq, fs, uvr, cm});
			chk("sst", 40000 << v[11:10], stc);
			i_pscr_host.wr(8'hd1, {2'b11, 3'(i), 3'(7 - i)});
			rchk(8'hd1, {2'b00, 3'(i), 3'(7 - i)});
			chk("pgd", i == 7 ? 5242880 : 10240 << i, pgc);
			chk("pod", 10240 << (7 - i), poc);
		end
		i_pscr_host.rd(8'h7c, r);
		chk("unmapped", 9'h100, r[8:0]);
		for (int i = 0; i < 16; i++)
		begin
			{flt, act} = 8'($urandom);
			repeat (3) @(negedge clk);
			rchk(8'h7b, {flt[6], &flt[6:5], 1'b0, flt[4], 4'h0});
			rchk(8'h7e, {flt[3:1], 3'h0, flt[0], 1'b0});
			chk("skip", v[12] & act, skp);
		end
		// let the last read pulse drop before freezing
		@(negedge clk);
		ce = 1'b0;
		i_pscr_host.wr(8'hd0, ~v[7:0]);
		i_pscr_host.rd(8'hd0, r);
		chk("frozen", 1'b0, r[9]);
		ce = 1'b1;
		rchk(8'hd0, v[7:0]);
		reset_dut;
		conclude;
	end
endmodule
